/* File: rtc_time_pkg.sv */
// Constants, register map and state types for the time-keeping core
package rtc_time_pkg;

	// ------------------------------------------------------------------
	// Register addresses
	// ------------------------------------------------------------------
	localparam logic [3:0] ADDR_CLOCK_MODE    = 4'h0;
	localparam logic [3:0] ADDR_IRQ_CTRL_STAT = 4'h1;
	localparam logic [3:0] ADDR_SECONDS       = 4'h2;
	localparam logic [3:0] ADDR_MINUTES       = 4'h3;
	localparam logic [3:0] ADDR_HOURS         = 4'h4;
	localparam logic [3:0] ADDR_DAY_OF_MONTH  = 4'h5;
	localparam logic [3:0] ADDR_DAY_OF_WEEK   = 4'h6;
	localparam logic [3:0] ADDR_MONTHS        = 4'h7;
	localparam logic [3:0] ADDR_YEARS         = 4'h8;

	// ------------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------------
	localparam int BIT_HOUR_MODE     = 2;
	localparam int BIT_MINUTE_EN     = 7;
	localparam int BIT_SECOND_EN     = 6;
	localparam int BIT_TICK_FLAG     = 5;
	localparam int BIT_PULSE_SELECT  = 4;
	localparam int BIT_ALARM_FLAG    = 3;
	localparam int BIT_COUNTDOWN_FLG = 2;
	localparam int BIT_ALARM_EN      = 1;
	localparam int BIT_COUNTDOWN_EN  = 0;
	localparam int BIT_HALT_FLAG     = 7;
	localparam int BIT_PM            = 5;

	// ------------------------------------------------------------------
	// Reset and limit values
	// ------------------------------------------------------------------
	localparam logic [6:0] SEC_RESET   = 7'h00;
	localparam logic [6:0] MIN_RESET   = 7'h00;
	localparam logic [5:0] HOUR_RESET  = 6'h00;
	localparam logic [5:0] DAY_RESET   = 6'h01;
	localparam logic [2:0] WDAY_RESET  = 3'h0;
	localparam logic [4:0] MONTH_RESET = 5'h01;
	localparam logic [7:0] YEAR_RESET  = 8'h00;
	localparam logic [6:0] SEC_MAX     = 7'h59;
	localparam logic [2:0] WDAY_MAX    = 3'h6;

	// ------------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------------
	localparam int CLK_PERIOD_NS  = 10;
	localparam int TICK_PERIOD_NS = 1_000_000_000;
	localparam int PULSE_TIME_NS  = 15_625_000;
	localparam int TICK_CYCLES    = TICK_PERIOD_NS / CLK_PERIOD_NS;
	localparam int PULSE_CYCLES   = PULSE_TIME_NS / CLK_PERIOD_NS;

	// ------------------------------------------------------------------
	// Types
	// ------------------------------------------------------------------
	typedef enum logic [1:0] {
		PIN_IDLE  = 2'b01,
		PIN_PULSE = 2'b10
	} pin_state_e;

	typedef struct packed {
		logic       active;
		logic       wr;
		logic       rd;
		logic [3:0] addr;
		logic [7:0] wdata;
	} reg_req_s;

	typedef struct packed {
		logic       hour_12;
		logic       minute_en;
		logic       second_en;
		logic       tick_flag;
		logic       pulse_sel;
		logic       alarm_flag;
		logic       countdown_flag;
		logic       alarm_en;
		logic       countdown_en;
		logic       halt_flag;
		logic [6:0] sec;
		logic [6:0] min;
		logic [5:0] hour;
		logic [5:0] day;
		logic [2:0] wday;
		logic [4:0] month;
		logic [7:0] year;
		logic [26:0] div_cnt;
		logic       pending;
		pin_state_e pin_state;
		logic [20:0] pulse_cnt;
		logic       irq_oe_n;
		logic [7:0] rdata;
	} rtc_state_s;

endpackage : rtc_time_pkg

/* File: rtc_time_status_regs.sv */
// Time-keeping counters, status flags and interrupt pin control
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// R1: Control bit 7 enables the once-per-minute interrupt source; default off.
// R2: Control bit 6 enables the once-per-second interrupt source; default off.
// R3: Bit 5 sets on minute/second interrupt; holds the pin until cleared while bit 4 is 0.
// R4: Bit 4 picks pin mode: 0 follows flags, 1 pulses per event.
// R5: Bit 3 sets on alarm match and stays until the host clears it.
// R6: Bit 2 sets on countdown event while bit 0 is set; with bit 4 at 0, host clears it to release the pin.
// R7: Bit 1 gates the alarm flag onto the interrupt pin.
// R8: Bit 0 gates countdown events onto the interrupt pin.
// R9: Seconds at 02h in BCD, tens 0-5 in bits 6:4, units 0-9.
// R10: Seconds bit 7 flags an oscillator stop or interruption.
// R11: Halt flag sticks until cleared; clear fails while oscillator is stopped.
// R12: Halt flag is always set after power-on.
// R13: Minutes at 03h in BCD, tens 0-5 in bits 6:4, bit 7 unused.
// R14: Twelve-hour hours at 04h: bit 5 PM, bit 4 tens, bits 3:0 units.
// R15: Twenty-four-hour hours: tens 0-2 in bits 5:4, units in bits 3:0.
// R16: Hour mode bit in the first control register sets layout and range.
// R17: Day of month at 05h in BCD, tens 0-3 in bits 5:4.
// R18: February gets day 29 when the year is divisible by four, 00 included.
// R19: Weekday at 06h holds 0 to 6 in bits 2:0.
// R20: Host gives weekday codes their meaning; device only cycles them.
// R21: Hour mode bit: 0 selects 24-hour (default), 1 selects 12-hour.
// R22: Month holds 1 to 12 in BCD, tens in bit 4.
// R23: Year holds 00 to 99 in BCD, tens in bits 7:4.
// R24: Counters freeze during host access; one pending tick is kept.
// R25: Each 1 Hz tick increments seconds and carries up to the year.
// R26: Twelve-hour count runs 12 to 11, toggling PM from 11 to 12.
module rtc_time_status_regs #(
	parameter int TICK_DIV   = rtc_time_pkg::TICK_CYCLES,
	parameter int PULSE_LEN  = rtc_time_pkg::PULSE_CYCLES
) (
	input  wire logic                  clk_i,
	input  wire logic                  reset_i,
	input  wire rtc_time_pkg::reg_req_s reg_req_i,
	input  wire logic                  osc_stopped_i,
	input  wire logic                  alarm_match_i,
	input  wire logic                  countdown_event_i,
	output logic [7:0]                 rdata_o,
	output logic                       irq_pin_oe_n_o
);
	import rtc_time_pkg::*;

	// ------------------------------------------------------------------
	// Arithmetic helpers
	// ------------------------------------------------------------------
	function automatic logic [7:0] bcd_inc(input logic [7:0] v);
		if (v[3:0] == 4'h9) begin
			bcd_inc = {v[7:4] + 4'h1, 4'h0};
		end else begin
			bcd_inc = {v[7:4], v[3:0] + 4'h1};
		end
	endfunction : bcd_inc

	function automatic logic is_leap(input logic [7:0] y);
		if (y[4]) begin
			is_leap = (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
		end else begin
			is_leap = (y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8);
		end
	endfunction : is_leap

	function automatic logic [5:0] month_days(input logic [4:0] m, input logic [7:0] y);
		if (m == 5'h02) begin
			month_days = is_leap(y) ? 6'h29 : 6'h28; // see R18
		end else if (m == 5'h04 || m == 5'h06 || m == 5'h09 || m == 5'h11) begin
			month_days = 6'h30;
		end else begin
			month_days = 6'h31;
		end
	endfunction : month_days

	function automatic logic [5:0] hour_next(input logic [5:0] h, input logic h12);
		logic [7:0] inc;
		inc = bcd_inc({2'h0, h});
		if (!h12) begin
			hour_next = (h == 6'h23) ? 6'h00 : inc[5:0]; // see R15
		end else if (h[4:0] == 5'h11) begin
			hour_next = {~h[BIT_PM], 5'h12}; // see R26
		end else if (h[4:0] == 5'h12) begin
			hour_next = {h[BIT_PM], 5'h01}; // see R26
		end else begin
			hour_next = {h[BIT_PM], inc[4:0]}; // see R14
		end
	endfunction : hour_next

	// ------------------------------------------------------------------
	// State and combinational helpers
	// ------------------------------------------------------------------
	rtc_state_s st_q;
	rtc_state_s st_d;
	logic       tick;
	logic       advance;
	logic       sec_wrap;
	logic       min_wrap;
	logic       hour_wrap;
	logic       day_wrap;
	logic       sec_event;
	logic       min_event;
	logic       wr_ctl2;
	logic       pulse_trig;
	logic       level_irq;

	assign tick      = !osc_stopped_i && (st_q.div_cnt == 27'(TICK_DIV - 1));
	assign advance   = !reg_req_i.active && (tick || st_q.pending); // see R24
	assign sec_wrap  = (st_q.sec == SEC_MAX);
	assign min_wrap  = sec_wrap && (st_q.min == SEC_MAX);
	assign hour_wrap = st_q.hour_12 ? (st_q.hour == 6'h31) : (st_q.hour == 6'h23);
	assign day_wrap  = min_wrap && hour_wrap;
	assign sec_event = advance && st_q.second_en; // see R2
	assign min_event = advance && sec_wrap && st_q.minute_en; // see R1
	assign wr_ctl2   = reg_req_i.active && reg_req_i.wr && (reg_req_i.addr == ADDR_IRQ_CTRL_STAT);
	assign pulse_trig = st_q.pulse_sel &&
		(sec_event || min_event || (countdown_event_i && st_q.countdown_en)); // see R4

	always_comb begin
		st_d = st_q;
		level_irq = 1'b0;

		// --------------------------------------------------------------
		// Prescaler and pending tick
		// --------------------------------------------------------------
		if (osc_stopped_i || tick) begin
			st_d.div_cnt = 27'h000_0000;
		end else begin
			st_d.div_cnt = st_q.div_cnt + 27'h000_0001;
		end
		if (reg_req_i.active && tick) begin
			st_d.pending = 1'b1; // see R24
		end else if (advance) begin
			st_d.pending = 1'b0;
		end

		// --------------------------------------------------------------
		// Time counters
		// --------------------------------------------------------------
		if (advance) begin
			st_d.sec = sec_wrap ? 7'h00 : 7'(bcd_inc({1'b0, st_q.sec})); // see R25
			if (sec_wrap) begin
				st_d.min = (st_q.min == SEC_MAX) ? 7'h00 : 7'(bcd_inc({1'b0, st_q.min}));
			end
			if (min_wrap) begin
				st_d.hour = hour_next(st_q.hour, st_q.hour_12); // see R16
			end
			if (day_wrap) begin
				st_d.wday = (st_q.wday == WDAY_MAX) ? 3'h0 : st_q.wday + 3'h1; // see R19
				if (st_q.day == month_days(st_q.month, st_q.year)) begin
					st_d.day = 6'h01;
					if (st_q.month == 5'h12) begin
						st_d.month = 5'h01; // see R22
						st_d.year = (st_q.year == 8'h99) ? 8'h00 : bcd_inc(st_q.year); // see R23
					end else begin
						st_d.month = 5'(bcd_inc({3'h0, st_q.month}));
					end
				end else begin
					st_d.day = 6'(bcd_inc({2'h0, st_q.day})); // see R17
				end
			end
		end

		// --------------------------------------------------------------
		// Register writes
		// --------------------------------------------------------------
		if (reg_req_i.active && reg_req_i.wr) begin
			if (reg_req_i.addr == ADDR_CLOCK_MODE) begin
				st_d.hour_12 = reg_req_i.wdata[BIT_HOUR_MODE]; // see R21
			end else if (reg_req_i.addr == ADDR_IRQ_CTRL_STAT) begin
				st_d.minute_en    = reg_req_i.wdata[BIT_MINUTE_EN];
				st_d.second_en    = reg_req_i.wdata[BIT_SECOND_EN];
				st_d.pulse_sel    = reg_req_i.wdata[BIT_PULSE_SELECT];
				st_d.alarm_en     = reg_req_i.wdata[BIT_ALARM_EN];
				st_d.countdown_en = reg_req_i.wdata[BIT_COUNTDOWN_EN];
			end else if (reg_req_i.addr == ADDR_SECONDS) begin
				st_d.sec = reg_req_i.wdata[6:0]; // see R9
				st_d.halt_flag = reg_req_i.wdata[BIT_HALT_FLAG];
			end else if (reg_req_i.addr == ADDR_MINUTES) begin
				st_d.min = reg_req_i.wdata[6:0]; // see R13
			end else if (reg_req_i.addr == ADDR_HOURS) begin
				st_d.hour = reg_req_i.wdata[5:0]; // see R14
			end else if (reg_req_i.addr == ADDR_DAY_OF_MONTH) begin
				st_d.day = reg_req_i.wdata[5:0]; // see R17
			end else if (reg_req_i.addr == ADDR_DAY_OF_WEEK) begin
				st_d.wday = reg_req_i.wdata[2:0]; // see R19
			end else if (reg_req_i.addr == ADDR_MONTHS) begin
				st_d.month = reg_req_i.wdata[4:0];
			end else if (reg_req_i.addr == ADDR_YEARS) begin
				st_d.year = reg_req_i.wdata;
			end
		end

		// --------------------------------------------------------------
		// Status flags: a set always beats a clear
		// --------------------------------------------------------------
		st_d.tick_flag = (st_q.tick_flag && !(wr_ctl2 && !reg_req_i.wdata[BIT_TICK_FLAG]))
			|| sec_event || min_event; // see R3
		st_d.alarm_flag = (st_q.alarm_flag && !(wr_ctl2 && !reg_req_i.wdata[BIT_ALARM_FLAG]))
			|| alarm_match_i; // see R5
		st_d.countdown_flag = (st_q.countdown_flag &&
			!(wr_ctl2 && !reg_req_i.wdata[BIT_COUNTDOWN_FLG]))
			|| (countdown_event_i && st_q.countdown_en); // see R6
		if (osc_stopped_i) begin
			st_d.halt_flag = 1'b1; // see R10, R11
		end

		// --------------------------------------------------------------
		// Interrupt pin
		// --------------------------------------------------------------
		case (st_q.pin_state)
			PIN_IDLE: begin
				if (pulse_trig) begin
					st_d.pin_state = PIN_PULSE;
					st_d.pulse_cnt = 21'h00_0000;
				end
			end
			PIN_PULSE: begin
				if (pulse_trig) begin
					st_d.pulse_cnt = 21'h00_0000;
				end else if (st_q.pulse_cnt == 21'(PULSE_LEN - 1)) begin
					st_d.pin_state = PIN_IDLE;
				end else begin
					st_d.pulse_cnt = st_q.pulse_cnt + 21'h00_0001;
				end
			end
			default: begin
				st_d.pin_state = PIN_IDLE;
			end
		endcase
		if (!st_q.pulse_sel) begin
			level_irq = st_q.tick_flag || (st_q.countdown_flag && st_q.countdown_en); // see R3, R8
		end
		level_irq = level_irq || (st_q.alarm_flag && st_q.alarm_en); // see R7
		st_d.irq_oe_n = !(level_irq || (st_d.pin_state == PIN_PULSE));

		// --------------------------------------------------------------
		// Read data
		// --------------------------------------------------------------
		if (reg_req_i.active && reg_req_i.rd) begin
			if (reg_req_i.addr == ADDR_CLOCK_MODE) begin
				st_d.rdata = {5'h00, st_q.hour_12, 2'h0};
			end else if (reg_req_i.addr == ADDR_IRQ_CTRL_STAT) begin
				st_d.rdata = {st_q.minute_en, st_q.second_en, st_q.tick_flag, st_q.pulse_sel,
					st_q.alarm_flag, st_q.countdown_flag, st_q.alarm_en, st_q.countdown_en};
			end else if (reg_req_i.addr == ADDR_SECONDS) begin
				st_d.rdata = {st_q.halt_flag, st_q.sec};
			end else if (reg_req_i.addr == ADDR_MINUTES) begin
				st_d.rdata = {1'b0, st_q.min};
			end else if (reg_req_i.addr == ADDR_HOURS) begin
				st_d.rdata = {2'h0, st_q.hour};
			end else if (reg_req_i.addr == ADDR_DAY_OF_MONTH) begin
				st_d.rdata = {2'h0, st_q.day};
			end else if (reg_req_i.addr == ADDR_DAY_OF_WEEK) begin
				st_d.rdata = {5'h00, st_q.wday};
			end else if (reg_req_i.addr == ADDR_MONTHS) begin
				st_d.rdata = {3'h0, st_q.month};
			end else if (reg_req_i.addr == ADDR_YEARS) begin
				st_d.rdata = st_q.year;
			end else begin
				st_d.rdata = 8'h00;
			end
		end
	end

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			st_q <= '{hour_12: 1'b0, minute_en: 1'b0, second_en: 1'b0, tick_flag: 1'b0,
				pulse_sel: 1'b0, alarm_flag: 1'b0, countdown_flag: 1'b0, alarm_en: 1'b0,
				countdown_en: 1'b0, halt_flag: 1'b1, sec: SEC_RESET, min: MIN_RESET,
				hour: HOUR_RESET, day: DAY_RESET, wday: WDAY_RESET, month: MONTH_RESET,
				year: YEAR_RESET, div_cnt: 27'h000_0000, pending: 1'b0,
				pin_state: PIN_IDLE, pulse_cnt: 21'h00_0000, irq_oe_n: 1'b1,
				rdata: 8'h00}; // see R12
		end else begin
			st_q <= st_d;
		end
	end

	assign rdata_o        = st_q.rdata;
	assign irq_pin_oe_n_o = st_q.irq_oe_n;

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (reset_i);

	sequence clear_halt_while_stopped;
		osc_stopped_i && reg_req_i.active && reg_req_i.wr &&
			(reg_req_i.addr == ADDR_SECONDS) && !reg_req_i.wdata[BIT_HALT_FLAG];
	endsequence

	sequence tick_during_access;
		reg_req_i.active && tick;
	endsequence

	sequence pending_released;
		st_q.pending && !reg_req_i.active;
	endsequence

	chk_halt_sets: assert property (osc_stopped_i |=> st_q.halt_flag) // see R10
		else $error("halt flag not set by oscillator stop");
	chk_halt_clear_blocked: assert property (clear_halt_while_stopped |=> st_q.halt_flag) // see R11
		else $error("halt flag cleared while oscillator stopped");
	chk_sec_bcd_range: assert property (st_q.sec[6:4] <= 3'h5 && st_q.sec[3:0] <= 4'h9 ||
		$past(reg_req_i.wr)) // see R9
		else $error("seconds out of BCD range");
	chk_freeze_during_access: assert property (reg_req_i.active && !reg_req_i.wr
		|=> $stable(st_q.sec) && $stable(st_q.min)) // see R24
		else $error("time counters moved during access");
	chk_pending_stored: assert property (tick_during_access |=> st_q.pending) // see R24
		else $error("tick during access not stored");
	chk_pending_serviced: assert property (pending_released |=> // see R24
		$changed(st_q.sec) && !st_q.pending)
		else $error("pending tick not serviced");
	chk_tick_flag_set: assert property (sec_event && !wr_ctl2 |=> st_q.tick_flag ##1 !st_q.irq_oe_n
		|| st_q.pulse_sel) // see R2, R3
		else $error("second event did not raise flag and pin");
	chk_set_beats_clear: assert property ( // see R6
		countdown_event_i && st_q.countdown_en && wr_ctl2 |=> st_q.countdown_flag)
		else $error("flag clear won over new event");
	chk_countdown_gate: assert property ( // see R8
		countdown_event_i && !st_q.countdown_en && !st_q.countdown_flag |=> !st_q.countdown_flag)
		else $error("disabled countdown event raised its flag");
	chk_second_gate: assert property ( // see R2
		advance && !st_q.second_en && !min_event && !st_q.tick_flag |=> !st_q.tick_flag)
		else $error("disabled second tick raised the flag");
	chk_hour_wrap: assert property ( // see R15
		advance && min_wrap && !st_q.hour_12 && st_q.hour == 6'h23 |=> st_q.hour == 6'h00)
		else $error("24-hour count did not wrap to zero");
	chk_leap_day: assert property ( // see R18
		advance && day_wrap && st_q.month == 5'h02 && st_q.day == 6'h28 && is_leap(st_q.year)
		|=> st_q.day == 6'h29)
		else $error("leap year February lost day 29");
	chk_pm_toggle: assert property ( // see R26
		advance && min_wrap && st_q.hour_12 && st_q.hour[4:0] == 5'h11
		|=> st_q.hour[BIT_PM] != $past(st_q.hour[BIT_PM]))
		else $error("PM indicator did not toggle at 11 to 12");
	chk_alarm_gate: assert property (st_q.alarm_flag && st_q.alarm_en |=> !irq_pin_oe_n_o) // see R7
		else $error("enabled alarm flag did not drive pin");
	chk_pulse_pin_low: assert property (pulse_trig |=> !irq_pin_oe_n_o) // see R4
		else $error("pulse mode event produced no pulse");
	chk_weekday_range: assert property (day_wrap && advance && st_q.wday == WDAY_MAX
		|=> st_q.wday == 3'h0) // see R19
		else $error("weekday did not wrap to zero");

endmodule : rtc_time_status_regs

`default_nettype wire

/* File: rtc_host_model.sv */
// Host-side register access model for the time-keeping core
`timescale 1ns/1ps
`default_nettype none

module rtc_host_model (
	input  wire logic                    clk_i,
	output var  rtc_time_pkg::reg_req_s  req_o
);
	import rtc_time_pkg::*;

	initial req_o = '0;

	// Whole set or read sequence lets at most one prescaler tick fall inside it
	task automatic open_access();
		@(posedge clk_i) req_o.active <= 1'b1;
	endtask : open_access

	task automatic close_access();
		@(posedge clk_i) req_o.active <= 1'b0;
	endtask : close_access

	// One byte per strobe; bus lines show stale inverse once released
	task automatic strobe(input logic wr, input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_i);
		req_o.wr    <= wr;
		req_o.rd    <= !wr;
		req_o.addr  <= a;
		req_o.wdata <= d;
		@(posedge clk_i);
		req_o.wr    <= 1'b0;
		req_o.rd    <= 1'b0;
		req_o.addr  <= ~a;
		req_o.wdata <= ~d;
	endtask : strobe

endmodule : rtc_host_model
`default_nettype wire

/* File: rtc_time_status_regs_test.sv */
// Self-checking bench for the time-keeping core
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin \
	check_count++; \
	if ((g) !== (e)) begin \
		error_cnt++; \
		$display("ERROR %s expected %h seen %h", nm, e, g); \
	end \
end

module rtc_time_status_regs_test;
	import rtc_time_pkg::*;
	localparam int TDIV = 20;
	localparam int PLEN = 4;
	localparam logic [7:0] RST_V [10] = '{8'h00, 8'h00, 8'h80, 8'h00, 8'h00,
		8'h01, 8'h00, 8'h01, 8'h00, 8'h00};
	// Mode, hour, day, month, year, weekday, then expected after one tick
	localparam logic [87:0] CAL [8] = '{
		88'h00_2328_0204_0600_2902_0400, 88'h00_2328_0201_0300_0103_0104,
		88'h00_2328_0200_0100_2902_0002, 88'h00_2331_1299_0500_0101_0006,
		88'h00_2030_0421_0021_3004_2100, 88'h04_1115_0610_0232_1506_1002,
		88'h04_3130_0421_0212_0105_2103, 88'h04_1210_0105_0101_1001_0501};
	logic        clk_i;
	logic        reset_i;
	logic        osc_stopped_i;
	logic        alarm_match_i;
	logic        countdown_event_i;
	logic [7:0]  rdata_o;
	logic        irq_pin_oe_n_o;
	wire         irq_line;
	reg_req_s    req;
	logic [11:0] exp_q[$];
	logic [11:0] ent;
	logic [87:0] c;
	logic [7:0]  v;
	logic [31:0] rng;
	int          error_cnt;
	int          check_count;

	// Open-drain pin with pull-up
	assign irq_line = irq_pin_oe_n_o ? 1'b1 : 1'b0;

	rtc_time_status_regs #(.TICK_DIV(TDIV), .PULSE_LEN(PLEN)) DUT (
		.clk_i(clk_i), .reset_i(reset_i), .reg_req_i(req),
		.osc_stopped_i(osc_stopped_i), .alarm_match_i(alarm_match_i),
		.countdown_event_i(countdown_event_i), .rdata_o(rdata_o),
		.irq_pin_oe_n_o(irq_pin_oe_n_o));

	rtc_host_model host (.clk_i(clk_i), .req_o(req));

	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end

	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction : xs

	task automatic cyc(input int n);
		repeat (n) @(posedge clk_i);
	endtask : cyc

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		host.strobe(1'b1, a, d);
	endtask : wr

	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		exp_q.push_back({a, e});
		host.strobe(1'b0, a, 8'h00);
	endtask : rd

	task automatic wrd(input logic [3:0] a, input logic [7:0] d, input logic [7:0] e);
		wr(a, d);
		rd(a, e);
	endtask : wrd

	task automatic put(input logic [3:0] a, input logic [7:0] d);
		host.open_access();
		wr(a, d);
		host.close_access();
	endtask : put

	// Read control/status, then write a new value
	task automatic ctl(input logic [7:0] d, input logic [7:0] e);
		host.open_access();
		rd(ADDR_IRQ_CTRL_STAT, e);
		wr(ADDR_IRQ_CTRL_STAT, d);
		host.close_access();
	endtask : ctl

	// Exactly one prescaler tick, oscillator stopped again afterwards
	task automatic one_tick();
		@(posedge clk_i) osc_stopped_i <= 1'b0;
		cyc(TDIV + 5);
		osc_stopped_i <= 1'b1;
		cyc(3);
	endtask : one_tick

	task automatic pulse(input logic alarm);
		@(posedge clk_i);
		alarm_match_i     <= alarm;
		countdown_event_i <= !alarm;
		@(posedge clk_i);
		alarm_match_i     <= 1'b0;
		countdown_event_i <= 1'b0;
	endtask : pulse

	task automatic pin(input logic e);
		cyc(2);
		#1;
		`CHK("irq pin", e, irq_line)
	endtask : pin

	task automatic test_done();
		$display("checks %0d errors %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : test_done

	// ------------------------------------------------------------------
	// Read data monitor
	// ------------------------------------------------------------------
	always @(posedge clk_i) begin
		if (req.active === 1'b1 && req.rd === 1'b1) begin
			#1;
			ent = exp_q.pop_front();
			`CHK($sformatf("reg %h", ent[11:8]), ent[7:0], rdata_o)
		end
	end

	// Limit far above the sequence length
	initial begin
		repeat (20000) @(posedge clk_i);
		error_cnt++;
		test_done();
	end

	// ------------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------------
	initial begin
		reset_i           = 1'b1;
		osc_stopped_i     = 1'b1;
		alarm_match_i     = 1'b0;
		countdown_event_i = 1'b0;
		rng               = 32'd97;
		error_cnt         = 0;
		check_count       = 0;
		cyc(12);
		reset_i <= 1'b0;
		host.open_access();
		for (int a = 0; a < 10; a++) begin
			rd(a[3:0], RST_V[a]);
		end
		wrd(4'hC, 8'hFF, 8'h00);
		wrd(ADDR_CLOCK_MODE, 8'hFF, 8'h04);
		wrd(ADDR_SECONDS, 8'h00, 8'h80);
		wr(ADDR_CLOCK_MODE, 8'h00);
		host.close_access();
		osc_stopped_i <= 1'b0;
		host.open_access();
		wrd(ADDR_SECONDS, 8'h00, 8'h00);
		host.close_access();
		osc_stopped_i <= 1'b1;
		cyc(2);
		host.open_access();
		rd(ADDR_SECONDS, 8'h80);
		for (int i = 0; i < 8; i++) begin
			rng = xs(rng);
			v = {1'b0, 3'(rng[7:0] % 8'd6), 4'(rng[15:8] % 8'd10)};
			wrd(ADDR_MINUTES, v, v);
			wrd(ADDR_SECONDS, v, v | 8'h80);
		end
		host.close_access();
		// Weekday codes only cycle; their names are the host's own
		for (int i = 0; i < 8; i++) begin
			c = CAL[i];
			host.open_access();
			wr(ADDR_CLOCK_MODE, c[87:80]);
			wr(ADDR_SECONDS, 8'h59);
			wr(ADDR_MINUTES, 8'h59);
			wr(ADDR_HOURS, c[79:72]);
			wr(ADDR_DAY_OF_MONTH, c[71:64]);
			wr(ADDR_MONTHS, c[63:56]);
			wr(ADDR_YEARS, c[55:48]);
			wr(ADDR_DAY_OF_WEEK, c[47:40]);
			host.close_access();
			one_tick();
			host.open_access();
			rd(ADDR_SECONDS, 8'h80);
			rd(ADDR_MINUTES, 8'h00);
			rd(ADDR_HOURS, c[39:32]);
			rd(ADDR_DAY_OF_MONTH, c[31:24]);
			rd(ADDR_MONTHS, c[23:16]);
			rd(ADDR_YEARS, c[15:8]);
			rd(ADDR_DAY_OF_WEEK, c[7:0]);
			host.close_access();
		end
		host.open_access();
		wr(ADDR_CLOCK_MODE, 8'h00);
		wr(ADDR_SECONDS, 8'h10);
		one_tick();
		rd(ADDR_SECONDS, 8'h90);
		host.close_access();
		cyc(2);
		host.open_access();
		rd(ADDR_SECONDS, 8'h91);
		host.close_access();
		ctl(8'h40, 8'h00);
		one_tick();
		pin(1'b0);
		ctl(8'h40, 8'h60);
		ctl(8'h80, 8'h40);
		pin(1'b1);
		put(ADDR_SECONDS, 8'h58);
		one_tick();
		pin(1'b1);
		one_tick();
		pin(1'b0);
		ctl(8'h00, 8'hA0);
		pulse(1'b0);
		pin(1'b1);
		ctl(8'h01, 8'h00);
		pulse(1'b0);
		pin(1'b0);
		cyc(8);
		pin(1'b0);
		ctl(8'h11, 8'h05);
		pin(1'b1);
		pulse(1'b0);
		pin(1'b0);
		cyc(PLEN);
		pin(1'b1);
		// Countdown event lands on the clearing write
		fork
			ctl(8'h00, 8'h15);
			begin
				cyc(3);
				pulse(1'b0);
			end
		join
		pulse(1'b1);
		pin(1'b1);
		ctl(8'h0A, 8'h0C);
		pin(1'b0);
		ctl(8'h02, 8'h0A);
		pin(1'b1);
		ctl(8'h00, 8'h02);
		cyc(4);
		`CHK("reads left", 0, exp_q.size())
		test_done();
	end

endmodule : rtc_time_status_regs_test
`default_nettype wire
